//--- rtl/rtc_regs.v
// time, calendar and alarm registers with update engine
// assumes a one-cycle read or write strobe per byte access
// How it works
// - seconds count 0x10, alarm 0x11, 7 bits
// - minutes count 0x12, alarm 0x13, 7 bits
// - hours 0x14, bit6 zero, bit7 afternoon
// - hours alarm 0x15, bit7 afternoon in 12h
// - weekday 0x16 low 3 bits, reset 1
// - day of month 0x17 six bits, reset 1
// - month 0x18 five bits, reset 1
// - month bit 7 always reads zero
// - year 0x19 eight bits, 0 to 99
// - status 0x1a read only, fixed low bits
// - status bit 7 shows update pending
// - control 0x1b, bit1 selects 24 hour
// - control bit2 selects binary or bcd
// - bit4 lets tick flag raise summary
// - bit5 lets match flag raise summary
// - bit7 aborts and freezes updates
// - bit7 clear advances counts each second
// - summary is OR of enabled flags
// - flag read clears, new events kept
// - pending first, increment later, then compare
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defines.vh"

module rtc_regs #(
    parameter TICK_CYCLES = `RTC_TICK_CYCLES,
    parameter PEND_CYCLES = `RTC_PEND_CYCLES,
    parameter UPDATE_CYCLES = `RTC_UPDATE_CYCLES
) (
    // clock and reset
    input wire clock_i,
    input wire srst_i,
    // register port
    input wire [7:0] addr_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [7:0] wdata_i,
    output reg [7:0] rdata_o,
    // event flags
    input wire flag_read_i,
    output reg tick_done_flag_o,
    output reg match_flag_o,
    output wire irq_summary_flag_o,
    output wire update_pending_o
);

    localparam ST_IDLE = 2'd0;
    localparam ST_PEND = 2'd1;
    localparam ST_INC = 2'd2;
    localparam ST_UPD = 2'd3;

    function [6:0] dec;
        input [7:0] v;
        input bin;
        begin
            if (bin) begin
                dec = v[6:0];
            end else begin
                dec = {3'b000, v[7:4]} * 7'd10 + {3'b000, v[3:0]};
            end
        end
    endfunction

    reg [7:0] seconds_count, seconds_alarm;
    reg [7:0] minutes_count, minutes_alarm;
    reg [7:0] hours_count, hours_alarm;
    reg [7:0] weekday_count;
    reg [7:0] monthday_count;
    reg [7:0] month_count;
    reg [7:0] year_count;
    reg [7:0] clock_control;
    reg update_pending;
    reg [1:0] state;
    reg [25:0] tick_cnt;
    reg [25:0] wait_cnt;
    reg [6:0] days_in_month;

    wire hour_format_sel;
    wire number_format_sel;
    wire tick_done_irq_en;
    wire match_irq_en;
    wire freeze;
    wire tick;
    wire do_inc;
    wire upd_done;
    wire alarm_hit;
    wire day_carry;
    wire at_eleven;
    wire [6:0] month_bin, year_bin;
    wire [55:0] cur_vec, nxt_vec, lo_vec, hi_vec;
    wire [6:0] at_max, step_en;

    // --------------------------------------------------------
    // control fields
    // --------------------------------------------------------
    // hour format select
    assign hour_format_sel = clock_control[`RTC_BIT_HOUR_FORMAT];
    assign number_format_sel = clock_control[`RTC_BIT_NUMBER_FORMAT];
    assign tick_done_irq_en = clock_control[`RTC_BIT_TICK_IRQ_EN];
    assign match_irq_en = clock_control[`RTC_BIT_MATCH_IRQ_EN];
    assign freeze = clock_control[`RTC_BIT_FREEZE];

    // --------------------------------------------------------
    // one second divider
    // --------------------------------------------------------
    assign tick = (tick_cnt == TICK_CYCLES[25:0] - 26'h0000001);

    always @(posedge clock_i) begin
        if (srst_i || tick) begin
            tick_cnt <= 26'h0000000;
        end else begin
            tick_cnt <= tick_cnt + 26'h0000001;
        end
    end

    // --------------------------------------------------------
    // update sequencer
    // --------------------------------------------------------
    assign do_inc = (state == ST_INC) && !freeze;
    assign upd_done = (state == ST_UPD) && (wait_cnt == 26'h0000000) && !freeze;

    always @(posedge clock_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            wait_cnt <= 26'h0000000;
            update_pending <= 1'b0;
        end else if (freeze) begin
            state <= ST_IDLE;
            update_pending <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (tick) begin
                        state <= ST_PEND;
                        update_pending <= 1'b1;
                        wait_cnt <= PEND_CYCLES[25:0] - 26'h0000001;
                    end
                end
                ST_PEND: begin
                    if (wait_cnt == 26'h0000000) begin
                        state <= ST_INC;
                    end else begin
                        wait_cnt <= wait_cnt - 26'h0000001;
                    end
                end
                ST_INC: begin
                    state <= ST_UPD;
                    wait_cnt <= UPDATE_CYCLES[25:0] - 26'h0000001;
                end
                ST_UPD: begin
                    if (wait_cnt == 26'h0000000) begin
                        state <= ST_IDLE;
                        update_pending <= 1'b0;
                    end else begin
                        wait_cnt <= wait_cnt - 26'h0000001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    update_pending <= 1'b0;
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // counter steps and carries
    // --------------------------------------------------------
    assign month_bin = dec(month_count, number_format_sel);
    assign year_bin = dec(year_count, number_format_sel);

    always @* begin
        case (month_bin)
            7'd2: days_in_month = (year_bin[1:0] == 2'b00) ? 7'd29 : 7'd28;
            7'd4, 7'd6, 7'd9, 7'd11: days_in_month = 7'd30;
            default: days_in_month = 7'd31;
        endcase
    end

    assign cur_vec = {year_count, month_count, monthday_count, weekday_count,
                      {2'b00, hours_count[5:0]}, minutes_count, seconds_count};
    assign lo_vec = {8'd0, 8'd1, 8'd1, 8'd1, {7'd0, ~hour_format_sel}, 8'd0, 8'd0};
    assign hi_vec = {8'd99, 8'd12, {1'b0, days_in_month}, 8'd7,
                     (hour_format_sel ? 8'd23 : 8'd12), 8'd59, 8'd59};

    // 12 hour day ends after 11 pm
    assign at_eleven = (cur_vec[23:16] == (number_format_sel ? 8'h0b : 8'h11));
    assign day_carry = step_en[2] & (hour_format_sel ? at_max[2] :
                       (at_eleven && hours_count[`RTC_BIT_AFTERNOON]));
    assign step_en = {step_en[5] & at_max[5], day_carry & at_max[4], day_carry,
                      day_carry, step_en[1] & at_max[1], step_en[0] & at_max[0], do_inc};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_step
            rtc_step u_step (
                .val_i(cur_vec[gi*8 +: 8]),
                .bin_mode_i(number_format_sel),
                .lo_i(lo_vec[gi*8 +: 7]),
                .hi_i(hi_vec[gi*8 +: 7]),
                .next_o(nxt_vec[gi*8 +: 8]),
                .at_max_o(at_max[gi])
            );
        end
    endgenerate

    // --------------------------------------------------------
    // time and calendar registers
    // --------------------------------------------------------
    always @(posedge clock_i) begin
        if (srst_i) begin
            seconds_count <= `RTC_RST_ZERO;
            minutes_count <= `RTC_RST_ZERO;
            hours_count <= `RTC_RST_ZERO;
            weekday_count <= `RTC_RST_ONE;
            monthday_count <= `RTC_RST_ONE;
            month_count <= `RTC_RST_ONE;
            year_count <= `RTC_RST_ZERO;
        end else if (wr_en_i) begin
            case (addr_i)
                `RTC_OFS_SECONDS: seconds_count <= wdata_i & `RTC_MASK_SECONDS;
                `RTC_OFS_MINUTES: minutes_count <= wdata_i & `RTC_MASK_MINUTES;
                `RTC_OFS_HOURS: hours_count <= wdata_i & `RTC_MASK_HOURS;
                `RTC_OFS_WEEKDAY: weekday_count <= wdata_i & `RTC_MASK_WEEKDAY;
                `RTC_OFS_MONTHDAY: monthday_count <= wdata_i & `RTC_MASK_MONTHDAY;
                `RTC_OFS_MONTHS: month_count <= wdata_i & `RTC_MASK_MONTHS;
                `RTC_OFS_YEARS: year_count <= wdata_i & `RTC_MASK_YEARS;
                default: begin
                end
            endcase
        end else if (do_inc) begin
            seconds_count <= nxt_vec[7:0];
            if (step_en[1]) begin
                minutes_count <= nxt_vec[15:8];
            end
            if (step_en[2]) begin
                hours_count[5:0] <= nxt_vec[21:16];
                // afternoon toggles at 11 to 12
                if (!hour_format_sel && at_eleven) begin
                    hours_count[`RTC_BIT_AFTERNOON] <= ~hours_count[`RTC_BIT_AFTERNOON];
                end
            end
            if (step_en[3]) begin
                weekday_count <= nxt_vec[31:24];
            end
            if (step_en[4]) begin
                monthday_count <= nxt_vec[39:32];
            end
            if (step_en[5]) begin
                month_count <= nxt_vec[47:40];
            end
            if (step_en[6]) begin
                year_count <= nxt_vec[55:48];
            end
        end
    end

    // --------------------------------------------------------
    // alarm and control registers
    // --------------------------------------------------------
    always @(posedge clock_i) begin
        if (srst_i) begin
            seconds_alarm <= `RTC_RST_ZERO;
            minutes_alarm <= `RTC_RST_ZERO;
            hours_alarm <= `RTC_RST_ZERO;
            clock_control <= `RTC_RST_CONTROL;
        end else if (wr_en_i) begin
            case (addr_i)
                `RTC_OFS_SECONDS_ALARM: seconds_alarm <= wdata_i & `RTC_MASK_SECONDS;
                `RTC_OFS_MINUTES_ALARM: minutes_alarm <= wdata_i & `RTC_MASK_MINUTES;
                `RTC_OFS_HOURS_ALARM: hours_alarm <= wdata_i & `RTC_MASK_HOURS;
                `RTC_OFS_CONTROL: clock_control <= wdata_i & `RTC_MASK_CONTROL;
                default: begin
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // alarm compare and event flags
    // --------------------------------------------------------
    // afternoon flag compared only in 12h
    assign alarm_hit = (seconds_count == seconds_alarm) &&
                       (minutes_count == minutes_alarm) &&
                       (hours_count[5:0] == hours_alarm[5:0]) &&
                       (hour_format_sel ||
                        hours_count[`RTC_BIT_AFTERNOON] == hours_alarm[`RTC_BIT_AFTERNOON]);

    always @(posedge clock_i) begin
        if (srst_i) begin
            tick_done_flag_o <= 1'b0;
            match_flag_o <= 1'b0;
        end else if (flag_read_i) begin
            tick_done_flag_o <= upd_done;
            match_flag_o <= upd_done & alarm_hit;
        end else begin
            // compare at end of update cycle
            tick_done_flag_o <= tick_done_flag_o | upd_done;
            match_flag_o <= match_flag_o | (upd_done & alarm_hit);
        end
    end

    // tick flag gated by its enable
    // match flag gated by its enable
    assign irq_summary_flag_o = (match_flag_o & match_irq_en) |
                                (tick_done_flag_o & tick_done_irq_en);
    assign update_pending_o = update_pending;

    // --------------------------------------------------------
    // read data
    // --------------------------------------------------------
    always @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_en_i) begin
            case (addr_i)
                `RTC_OFS_SECONDS: rdata_o <= seconds_count;
                `RTC_OFS_SECONDS_ALARM: rdata_o <= seconds_alarm;
                `RTC_OFS_MINUTES: rdata_o <= minutes_count;
                `RTC_OFS_MINUTES_ALARM: rdata_o <= minutes_alarm;
                `RTC_OFS_HOURS: rdata_o <= hours_count;
                `RTC_OFS_HOURS_ALARM: rdata_o <= hours_alarm;
                `RTC_OFS_WEEKDAY: rdata_o <= weekday_count;
                `RTC_OFS_MONTHDAY: rdata_o <= monthday_count;
                `RTC_OFS_MONTHS: rdata_o <= {1'b0, month_count[6:0]};
                `RTC_OFS_YEARS: rdata_o <= year_count;
                `RTC_OFS_STATUS: rdata_o <= {update_pending, `RTC_STATUS_FIXED};
                `RTC_OFS_CONTROL: rdata_o <= clock_control;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- rtl/rtc_defines.vh
// register offsets, field masks, reset values and timing counts
// assumes a 40 MHz system clock and byte-wide register access
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define RTC_OFS_SECONDS 8'h10
`define RTC_OFS_SECONDS_ALARM 8'h11
`define RTC_OFS_MINUTES 8'h12
`define RTC_OFS_MINUTES_ALARM 8'h13
`define RTC_OFS_HOURS 8'h14
`define RTC_OFS_HOURS_ALARM 8'h15
`define RTC_OFS_WEEKDAY 8'h16
`define RTC_OFS_MONTHDAY 8'h17
`define RTC_OFS_MONTHS 8'h18
`define RTC_OFS_YEARS 8'h19
`define RTC_OFS_STATUS 8'h1a
`define RTC_OFS_CONTROL 8'h1b

// ------------------------------------------------------------
// writable bits per register
// ------------------------------------------------------------
`define RTC_MASK_SECONDS 8'h7f
`define RTC_MASK_MINUTES 8'h7f
`define RTC_MASK_HOURS 8'hbf
`define RTC_MASK_WEEKDAY 8'h07
`define RTC_MASK_MONTHDAY 8'h3f
`define RTC_MASK_MONTHS 8'h1f
`define RTC_MASK_YEARS 8'hff
`define RTC_MASK_CONTROL 8'hb6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RTC_RST_ZERO 8'h00
`define RTC_RST_ONE 8'h01
`define RTC_RST_CONTROL 8'h02
`define RTC_STATUS_FIXED 7'h20

// ------------------------------------------------------------
// control and hour field positions
// ------------------------------------------------------------
`define RTC_BIT_HOUR_FORMAT 1
`define RTC_BIT_NUMBER_FORMAT 2
`define RTC_BIT_TICK_IRQ_EN 4
`define RTC_BIT_MATCH_IRQ_EN 5
`define RTC_BIT_FREEZE 7
`define RTC_BIT_AFTERNOON 7

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RTC_CLOCK_KHZ 40000
`define RTC_TICK_CYCLES 40000000
`define RTC_PEND_NS 244100
`define RTC_PEND_CYCLES ((`RTC_PEND_NS * (`RTC_CLOCK_KHZ / 1000) + 999) / 1000)
`define RTC_UPDATE_NS 30500
`define RTC_UPDATE_CYCLES ((`RTC_UPDATE_NS * `RTC_CLOCK_KHZ) / 1000000)

`endif

//--- rtl/rtc_step.v
// one time/calendar counter step with wrap, in bcd or binary
// assumes lo and hi are plain binary and val is in the selected coding
`timescale 1ns/100ps
`default_nettype none

module rtc_step (
    // counter value and coding
    input wire [7:0] val_i,
    input wire bin_mode_i,
    // wrap limits, binary
    input wire [6:0] lo_i,
    input wire [6:0] hi_i,
    // result
    output wire [7:0] next_o,
    output wire at_max_o
);

    function [7:0] enc;
        input [6:0] v;
        input bin;
        reg [6:0] tens;
        reg [6:0] ones;
        begin
            tens = v / 7'd10;
            ones = v % 7'd10;
            if (bin) begin
                enc = {1'b0, v};
            end else begin
                enc = {tens[3:0], ones[3:0]};
            end
        end
    endfunction

    wire [7:0] bcd_inc;

    // --------------------------------------------------------
    // increment and wrap
    // --------------------------------------------------------
    assign bcd_inc = (val_i[3:0] == 4'h9) ? {val_i[7:4] + 4'h1, 4'h0} : val_i + 8'h01;
    assign at_max_o = (val_i == enc(hi_i, bin_mode_i));
    assign next_o = at_max_o ? enc(lo_i, bin_mode_i) :
                    (bin_mode_i ? val_i + 8'h01 : bcd_inc);

endmodule
`default_nettype wire

//--- test/rtc_regs_properties.sv
// concurrent checks on the time/calendar register block ports
// assumes it is bound to rtc_regs and watches only its ports
`timescale 1ns/100ps
`default_nettype none

module rtc_regs_properties #(
    parameter TICK_CYCLES = 200
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    // event flags
    input wire logic flag_read_i,
    input wire logic tick_done_flag_o,
    input wire logic match_flag_o,
    input wire logic irq_summary_flag_o,
    input wire logic update_pending_o
);
    // ------------------------------------------------------------
    // shadow of control and of the second divider
    // ------------------------------------------------------------
    logic [7:0] ctl;
    int div;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctl <= 8'h02;
            div <= 0;
        end else begin
            div <= (div == TICK_CYCLES - 1) ? 0 : div + 1;
            if (wr_en_i && addr_i == 8'h1b) begin
                ctl <= wdata_i & 8'hb6;
            end
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    sequence s_rd(logic [7:0] a);
        rd_en_i && addr_i == a;
    endsequence

    sequence s_pend_start;
        $rose(update_pending_o);
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_status_read: assert property (
        s_rd(8'h1a) |=> rdata_o == {$past(update_pending_o), 7'h20})
        else $error("status read wrong");
    a_month_bits: assert property (
        s_rd(8'h18) |=> rdata_o[7:5] == 3'b000)
        else $error("month upper bits set");
    a_hours_bit6: assert property (
        s_rd(8'h14) |=> !rdata_o[6])
        else $error("hours bit 6 set");
    a_weekday_bits: assert property (
        s_rd(8'h16) |=> rdata_o[7:3] == 5'h00)
        else $error("weekday upper bits set");
    a_irq_summary: assert property (
        irq_summary_flag_o == ((match_flag_o && ctl[5]) || (tick_done_flag_o && ctl[4])))
        else $error("summary flag wrong");
    a_flag_clear: assert property (
        flag_read_i |=> (!match_flag_o && !tick_done_flag_o) || $fell(update_pending_o))
        else $error("flags not cleared");
    a_pending_len: assert property (
        s_pend_start |-> ##14 (update_pending_o || ctl[7]) ##1 !update_pending_o)
        else $error("pending window length wrong");
    a_update_end: assert property (
        $fell(update_pending_o) |-> tick_done_flag_o || ctl[7])
        else $error("update end without flag");
    a_freeze_block: assert property (
        ctl[7] |=> !$rose(update_pending_o))
        else $error("update started while frozen");
    a_match_time: assert property (
        $rose(match_flag_o) |-> $fell(update_pending_o))
        else $error("match flag outside update end");
    a_tick_period: assert property (
        s_pend_start |-> div == 0)
        else $error("tick period wrong");
endmodule

bind rtc_regs rtc_regs_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .addr_i(addr_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .flag_read_i(flag_read_i),
    .tick_done_flag_o(tick_done_flag_o),
    .match_flag_o(match_flag_o),
    .irq_summary_flag_o(irq_summary_flag_o),
    .update_pending_o(update_pending_o)
);

`default_nettype wire

//--- test/rtc_host_model.sv
// host processor model driving the byte strobe register port
// assumes the caller runs its tasks one at a time
`timescale 1ns/100ps
`default_nettype none

module rtc_host_model (
    // clock and read data
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    // strobes and bus
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_en_o = 1'b0,
    output logic rd_en_o = 1'b0,
    output logic flag_read_o = 1'b0
);
    // released bus lines show the inverse of their last value
    task automatic strobe(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clock_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_en_o = w;
        rd_en_o = !w;
        @(posedge clock_i);
        #1;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        strobe(a, d, 1'b1);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        strobe(a, 8'h00, 1'b0);
        d = rdata_i;
    endtask

    task automatic clr_flags;
        @(posedge clock_i);
        #1;
        flag_read_o = 1'b1;
        @(posedge clock_i);
        #1;
        flag_read_o = 1'b0;
    endtask

    task automatic load_all(input logic [7:0] v[10], input logic [7:0] ctl);
        wr_reg(8'h1b, ctl | 8'h80);
        for (int i = 0; i < 10; i++) begin
            wr_reg(8'h10 + 8'(i), v[i]);
        end
        wr_reg(8'h1b, ctl);
    endtask
endmodule

`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the time/calendar register block
// assumes short divider counts set by parameters below
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    wire [7:0] addr;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire wr_en;
    wire rd_en;
    wire flag_read;
    wire tick_flag;
    wire match_flag;
    wire irq_flag;
    wire pending;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // rows: address, write data, expected read back
    logic [23:0] rows [13] = '{24'h1bffb6, 24'h10ff7f, 24'h11ff7f, 24'h12ff7f,
        24'h13ff7f, 24'h14ffbf, 24'h15ffbf, 24'h16ff07, 24'h17ff3f, 24'h18ff1f,
        24'h19ffff, 24'h1aff20, 24'h1eff00};
    logic [7:0] va [10] = '{8'h59, 8'h00, 8'h59, 8'h00, 8'h23, 8'h00, 8'h07, 8'h31,
        8'h12, 8'h99};
    logic [7:0] ea [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
        8'h01, 8'h00};
    logic [7:0] vb [10] = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h8b, 8'h0c, 8'h03, 8'h1c,
        8'h02, 8'h01};
    logic [7:0] eb [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h0c, 8'h04, 8'h01,
        8'h03, 8'h01};
    logic [7:0] er [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
        8'h01, 8'h00, 8'h20, 8'h02};

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    rtc_regs #(.TICK_CYCLES(200), .PEND_CYCLES(10), .UPDATE_CYCLES(4)) dut (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .addr_i(addr),
        .wr_en_i(wr_en),
        .rd_en_i(rd_en),
        .wdata_i(wdata),
        .rdata_o(rdata),
        .flag_read_i(flag_read),
        .tick_done_flag_o(tick_flag),
        .match_flag_o(match_flag),
        .irq_summary_flag_o(irq_flag),
        .update_pending_o(pending)
    );

    rtc_host_model host (
        .clock_i(clock_i),
        .rdata_i(rdata),
        .addr_o(addr),
        .wdata_o(wdata),
        .wr_en_o(wr_en),
        .rd_en_o(rd_en),
        .flag_read_o(flag_read)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd_reg(a, d);
        check($sformatf("reg %h", a), d, e);
    endtask

    task automatic rd_all(input logic [7:0] e[10]);
        for (int i = 0; i < 10; i++) begin
            rd_chk(8'h10 + 8'(i), e[i]);
        end
    endtask

    task automatic flags(input logic [2:0] e);
        check("tick match irq", {5'h00, tick_flag, match_flag, irq_flag}, {5'h00, e});
    endtask

    task automatic wait_pend(input logic lvl);
        int n;
        n = 0;
        while (pending !== lvl && n < 400) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check("pending", {7'h00, pending}, {7'h00, lvl});
    endtask

    task automatic results;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        repeat (10) @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        for (int i = 0; i < 13; i++) begin
            host.wr_reg(rows[i][23:16], rows[i][15:8]);
            rd_chk(rows[i][23:16], rows[i][7:0]);
        end
        // bcd, 24 hour, full rollover
        host.load_all(va, 8'h32);
        wait_pend(1'b1);
        rd_chk(8'h1a, 8'ha0);
        rd_chk(8'h10, 8'h59);
        wait_pend(1'b0);
        flags(3'b111);
        rd_all(ea);
        host.clr_flags();
        flags(3'b000);
        // binary, 12 hour, no leap february
        host.load_all(vb, 8'h24);
        wait_pend(1'b1);
        wait_pend(1'b0);
        flags(3'b111);
        rd_all(eb);
        host.wr_reg(8'h1b, 8'h04);
        flags(3'b110);
        host.wr_reg(8'h1b, 8'h14);
        flags(3'b111);
        host.clr_flags();
        // freeze in mid window
        wait_pend(1'b1);
        host.wr_reg(8'h1b, 8'h94);
        @(posedge clock_i);
        #1;
        check("abort", {7'h00, pending}, 8'h00);
        repeat (300) @(posedge clock_i);
        #1;
        flags(3'b000);
        rd_chk(8'h10, 8'h00);
        host.wr_reg(8'h1b, 8'h14);
        wait_pend(1'b1);
        wait_pend(1'b0);
        rd_chk(8'h10, 8'h01);
        // reset in mid run
        srst_i = 1'b1;
        repeat (10) @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        flags(3'b000);
        for (int i = 0; i < 12; i++) begin
            rd_chk(8'h10 + 8'(i), er[i]);
        end
        results();
    end
endmodule

`default_nettype wire
